// >>> irbm_defines.vh
// register map and field layout of the interrupt batch read monitor
`ifndef IRBM_DEFINES_VH
`define IRBM_DEFINES_VH

`define IRBM_ADDR_W              8
`define IRBM_NUM_MON             13
`define IRBM_IDX_W               4

`define IRBM_SERIAL0_MON_OFS     8'h00
`define IRBM_SERIAL1_MON_OFS     8'h04
`define IRBM_SERIAL2_MON_OFS     8'h08
`define IRBM_SERIAL3_MON_OFS     8'h0c
`define IRBM_SERIAL4_RX_MON_OFS  8'h10
`define IRBM_SERIAL5_RX_MON_OFS  8'h14
`define IRBM_SERIAL6_RX_MON_OFS  8'h18
`define IRBM_SERIAL7_RX_MON_OFS  8'h1c
`define IRBM_SERIAL4_TS_MON_OFS  8'h20
`define IRBM_SERIAL5_TS_MON_OFS  8'h24
`define IRBM_SERIAL6_TS_MON_OFS  8'h28
`define IRBM_SERIAL7_TS_MON_OFS  8'h2c
`define IRBM_PULSE_GEN_MON_OFS   8'h30
`define IRBM_DMA_SELECT_OFS      8'h40
`define IRBM_IRQ_STATUS_OFS      8'h44
`define IRBM_IRQ_CLEAR_OFS       8'h48
`define IRBM_IRQ_ENABLE_OFS      8'h4c

`define IRBM_FULL_RX_BIT         0
`define IRBM_FULL_TX_BIT         1
`define IRBM_FULL_ST_BIT         2
`define IRBM_TS_TX_BIT           0
`define IRBM_TS_ST_BIT           1
`define IRBM_RX_ONLY_BIT         0
`define IRBM_PULSE_GEN_W         9

`define IRBM_DMA_RX_LSB          0
`define IRBM_DMA_TX_LSB          8
`define IRBM_DMA_SELECT_W        16

`define IRBM_DMA_SELECT_RESET    16'h0000
`define IRBM_IRQ_ENABLE_RESET    13'h0000
`define IRBM_IRQ_STATUS_RESET    13'h0000

`endif

// >>> irbm_monitor.v
// interrupt batch read monitor with apb register access
//
// Notes on behaviour
// [R1] four full monitors for vectors 31..34 show serial channels 0..3
// [R2] full monitor: bit 2 status, bit 1 transmit, bit 0 receive
// [R3] full monitor bits 31..3 always read zero
// [R4] a request steered to dma reads zero in its monitor
// [R5] receive monitors for vectors 35,37,58,60 show serial channels 4..7
// [R6] receive monitor: bit 0 receive pending, bits 31..1 zero
// [R7] transmit/status monitors for vectors 36,38,59,61 show channels 4..7
// [R8] transmit/status monitor: bit 1 status, bit 0 transmit, rest zero
// [R9] one monitor for vector 39 gathers nine pulse generator requests
// [R10] pulse monitor bits 8..0 are channels 20,18,16,12,10,8,4,2,0
// [R11] monitor bits follow live request levels; writes to monitors ignored
`timescale 1ns/1ps
`default_nettype none
`include "irbm_defines.vh"

module irbm_monitor (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        pclken,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  serial_rx_req,
  input  wire [7:0]  serial_tx_req,
  input  wire [7:0]  serial_st_req,
  input  wire [8:0]  pulse_gen_request_bits,
  output reg  [7:0]  serial_rx_dma_req,
  output reg  [7:0]  serial_tx_dma_req,
  output reg         irq
);

  reg  [15:0] dma_request_select;
  reg  [12:0] irq_status;
  reg  [12:0] irq_enable;
  reg  [12:0] pend_prev;

  wire [7:0]  rx_int;
  wire [7:0]  tx_int;
  wire [31:0] mon [0:12];
  wire [12:0] pend;

  // dma-steered requests are hidden from the interrupt view
  assign rx_int = serial_rx_req &
    ~dma_request_select[`IRBM_DMA_RX_LSB +: 8];  // see [R4]
  assign tx_int = serial_tx_req &
    ~dma_request_select[`IRBM_DMA_TX_LSB +: 8];  // see [R4]

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_full
      // channels 0..3 carry all three requests
      assign mon[i] = {29'h0000000,
                       serial_st_req[i],
                       tx_int[i],
                       rx_int[i]};  // see [R1] see [R2] see [R3]
    end
    for (i = 0; i < 4; i = i + 1) begin : g_split
      assign mon[4 + i] = {31'h00000000,
                           rx_int[4 + i]};  // see [R5] see [R6]
      assign mon[8 + i] = {30'h00000000,
                           serial_st_req[4 + i],
                           tx_int[4 + i]};  // see [R7] see [R8]
    end
    for (i = 0; i < `IRBM_NUM_MON; i = i + 1) begin : g_pend
      assign pend[i] = |mon[i];
    end
  endgenerate

  // input already ordered 20,18,16,12,10,8,4,2,0 from msb down
  assign mon[12] = {23'h000000,
                    pulse_gen_request_bits};  // see [R9] see [R10]

  // decode of the monitor window, used by read path
  function [4:0] mon_index;
    input [`IRBM_ADDR_W-1:0] a;
    begin
      case (a)
        `IRBM_SERIAL0_MON_OFS:    mon_index = 5'h10;
        `IRBM_SERIAL1_MON_OFS:    mon_index = 5'h11;
        `IRBM_SERIAL2_MON_OFS:    mon_index = 5'h12;
        `IRBM_SERIAL3_MON_OFS:    mon_index = 5'h13;
        `IRBM_SERIAL4_RX_MON_OFS: mon_index = 5'h14;
        `IRBM_SERIAL5_RX_MON_OFS: mon_index = 5'h15;
        `IRBM_SERIAL6_RX_MON_OFS: mon_index = 5'h16;
        `IRBM_SERIAL7_RX_MON_OFS: mon_index = 5'h17;
        `IRBM_SERIAL4_TS_MON_OFS: mon_index = 5'h18;
        `IRBM_SERIAL5_TS_MON_OFS: mon_index = 5'h19;
        `IRBM_SERIAL6_TS_MON_OFS: mon_index = 5'h1a;
        `IRBM_SERIAL7_TS_MON_OFS: mon_index = 5'h1b;
        `IRBM_PULSE_GEN_MON_OFS:  mon_index = 5'h1c;
        default:                  mon_index = 5'h00;
      endcase
    end
  endfunction

  wire                    setup;
  wire                    hi_ok;
  wire [`IRBM_ADDR_W-1:0] a8;
  wire [4:0]              midx;
  wire                    is_dma;
  wire                    is_stat;
  wire                    is_clr;
  wire                    is_en;
  wire                    mapped;
  wire                    wr_en;
  wire                    clr_hit;

  // answer in the first access cycle: setup is seen, flops load at once
  assign setup   = psel & ~penable & ~pready;
  assign hi_ok   = (paddr[31:`IRBM_ADDR_W] == 24'h000000);
  assign a8      = paddr[`IRBM_ADDR_W-1:0];
  assign midx    = mon_index(a8);
  assign is_dma  = hi_ok & (a8 == `IRBM_DMA_SELECT_OFS);
  assign is_stat = hi_ok & (a8 == `IRBM_IRQ_STATUS_OFS);
  assign is_clr  = hi_ok & (a8 == `IRBM_IRQ_CLEAR_OFS);
  assign is_en   = hi_ok & (a8 == `IRBM_IRQ_ENABLE_OFS);
  assign mapped  = (hi_ok & midx[4]) | is_dma | is_stat | is_clr | is_en;
  // writes commit at the access edge, the one where the master sees pready
  assign wr_en   = pclken & psel & penable & pready & pwrite;
  assign clr_hit = wr_en & is_clr;

  reg [31:0] next_prdata;

  always @* begin
    next_prdata = 32'h00000000;
    if (!pwrite) begin
      if (hi_ok & midx[4]) begin
        next_prdata = mon[midx[3:0]];  // see [R11]
      end else if (is_dma) begin
        next_prdata = {16'h0000, dma_request_select};
      end else if (is_stat) begin
        next_prdata = {19'h00000, irq_status};
      end else if (is_en) begin
        next_prdata = {19'h00000, irq_enable};
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (pclken) begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= next_prdata;
      end
    end
  end

  // monitors take no write: only the control words decode a write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_request_select <= `IRBM_DMA_SELECT_RESET;
      irq_enable         <= `IRBM_IRQ_ENABLE_RESET;
    end else if (wr_en) begin  // see [R11]
      if (is_dma) begin
        dma_request_select <= pwdata[`IRBM_DMA_SELECT_W-1:0];
      end
      if (is_en) begin
        irq_enable <= pwdata[`IRBM_NUM_MON-1:0];
      end
    end
  end

  // a monitor turning non-empty is an event; set beats a same-cycle clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_prev  <= 13'h0000;
      irq_status <= `IRBM_IRQ_STATUS_RESET;
      irq        <= 1'b0;
    end else if (pclken) begin
      pend_prev  <= pend;
      irq_status <= (irq_status &
                     ~(clr_hit ? pwdata[12:0] : 13'h0000)) |
                    (pend & ~pend_prev);
      irq        <= |(irq_status & irq_enable);
    end
  end

  // steered requests go out as dma requests, one flop late
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_rx_dma_req <= 8'h00;
      serial_tx_dma_req <= 8'h00;
    end else if (pclken) begin
      serial_rx_dma_req <= serial_rx_req &
        dma_request_select[`IRBM_DMA_RX_LSB +: 8];  // see [R4]
      serial_tx_dma_req <= serial_tx_req &
        dma_request_select[`IRBM_DMA_TX_LSB +: 8];  // see [R4]
    end
  end

endmodule
`default_nettype wire

// >>> irbm_properties.sv
// assertions on the request monitor ports
`timescale 1ns/1ps
`default_nettype none
module irbm_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pclken,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [7:0]  serial_rx_req,
  input wire logic [7:0]  serial_rx_dma_req,
  input wire logic [8:0]  pulse_gen_request_bits
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read setup as the slave takes it; a low enable stalls the answer
  wire rd = pclken && psel && !penable && !pready && !pwrite;
  a_ready_next: assert property (
    rd |=> pready) else $error("no ready");
  a_full_zero: assert property (
    rd && paddr < 16 |=> !prdata[31:3]) else $error("full rsv");
  a_rx_zero: assert property (
    rd && paddr[7:4] == 1 |=> !prdata[31:1]) else $error("rx rsv");
  a_ts_zero: assert property (
    rd && paddr[7:4] == 2 |=> !prdata[31:2]) else $error("ts rsv");
  a_ch0_recv: assert property (
    rd && !paddr |=> !prdata[0] || $past(serial_rx_req[0]))
    else $error("rx0");
  a_rx4_recv: assert property (
    rd && paddr == 16 && !serial_rx_req[4] |=> !prdata[0]) else $error("rx4");
  a_pg_order: assert property (
    rd && paddr == 48 |=>
    prdata == {23'h0, $past(pulse_gen_request_bits)}) else $error("pg");
  a_dma_masked: assert property (
    $past(pclken) |-> !(serial_rx_dma_req & ~$past(serial_rx_req)))
    else $error("dma");
endmodule
bind irbm_monitor irbm_properties u_props (
  .pclk                   (pclk),
  .presetn                (presetn),
  .pclken                 (pclken),
  .psel                   (psel),
  .penable                (penable),
  .pwrite                 (pwrite),
  .paddr                  (paddr),
  .prdata                 (prdata),
  .pready                 (pready),
  .serial_rx_req          (serial_rx_req),
  .serial_rx_dma_req      (serial_rx_dma_req),
  .pulse_gen_request_bits (pulse_gen_request_bits)
);
`default_nettype wire

// >>> irbm_sources.sv
// request sources on the far side of the monitor
`timescale 1ns/1ps
`default_nettype none
module irbm_sources (
  input  wire logic        pclk,
  input  wire logic [32:0] value,
  output var  logic [32:0] req
);
  always @(posedge pclk) req <= value;
endmodule
`default_nettype wire

// >>> irbm_monitor_test.sv
// self-checking bench for the request monitor
`timescale 1ns/1ps
`default_nettype none
module irbm_monitor_test;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic        pready, pslverr, irq;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic [32:0] src = 0, req;
  logic [7:0]  rdma, tdma;
  logic        en = 1;
  integer      seed = 21, miscompares = 0, check_count = 0, cyc = 0, dsel;
  always #20 pclk = ~pclk;
  irbm_sources far (.pclk(pclk), .value(src), .req(req));
  irbm_monitor uut (.pclk(pclk), .presetn(presetn), .pclken(en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .serial_rx_req(req[7:0]), .serial_tx_req(req[15:8]),
    .serial_st_req(req[23:16]), .pulse_gen_request_bits(req[32:24]),
    .serial_rx_dma_req(rdma), .serial_tx_dma_req(tdma));
  always @(posedge pclk) if (cyc++ == 4000) begin
    chk(0, 1, "timeout");
    summarize;
  end
  task automatic chk(input [31:0] seen, exp, input string nm);
    check_count++;
    if (seen !== exp) $display("ERROR %s expected %h seen %h", nm, exp, seen);
    miscompares += (seen !== exp);
  endtask
  task apb(input w, input [31:0] a, d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1); // no fixed latency assumed
    {e, r} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  function [31:0] mon(input integer n);
    logic [7:0] rm, tm;
    {rm, tm} = {src[7:0] & ~dsel[7:0], src[15:8] & ~dsel[15:8]};
    if (n < 4) return {29'h0, src[16+n], tm[n], rm[n]};
    if (n < 8) return {31'h0, rm[n]};
    if (n < 12) return {30'h0, src[12+n], tm[n-4]};
    return {23'h0, src[32:24]};
  endfunction
  task summarize;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    for (int k = 0; k < 8; k++) begin
      src <= 33'({$random(seed), $random(seed)});
      dsel = $random(seed);
      apb(1, 32'h40, {16'h0, dsel[15:0]});
      apb(1, 4 * k, '1);
      for (int i = 0; i < 13; i++) begin
        apb(0, 4 * i, 0);
        chk(r, mon(i), "monitor");
        chk(e, 0, "monitor error");
      end
      chk({tdma, rdma}, src[15:0] & dsel[15:0], "dma request");
    end
    src <= 0;
    apb(0, 32'h34, 0);
    chk(e, 1, "unmapped");
    chk(r, 0, "unmapped data");
    apb(1, 32'h48, 32'h1fff);
    src <= 33'h10000;
    apb(1, 32'h4c, 1);
    apb(0, 32'h44, 0);
    chk(r, 1, "status");
    chk(irq, 1, "irq on");
    apb(1, 32'h4c, 0);
    apb(1, 32'h48, 1);
    apb(0, 32'h44, 0);
    chk(r, 0, "status");
    chk(irq, 0, "irq off");
    // a low clock enable must hold the dma outputs where they were
    apb(1, 32'h40, 32'h00ff);
    src <= 33'hff;
    repeat (2) @(posedge pclk);
    {en, src} <= {1'b0, 33'h0};
    repeat (4) @(posedge pclk);
    chk(rdma, 8'hff, "stalled dma");
    en <= 1;
    repeat (3) @(posedge pclk);
    chk(rdma, 0, "released dma");
    summarize;
  end
endmodule
`default_nettype wire
